/* File: rtl/ctf_defs.svh */
// Offsets, field positions and frame counts of the C-bit transmit formatter
`ifndef CTF_DEFS_SVH
`define CTF_DEFS_SVH
`define CTF_CTRL_OFS 12'h000
`define CTF_ERR_OFS 12'h004
`define CTF_STAT_OFS 12'h008
`define CTF_CTRL_RST 32'h0000_0000
`define CTF_ERR_RST 32'h0000_0000
`define CTF_C_FGEN 0
`define CTF_C_PGEN 1
`define CTF_C_ARDD 2
`define CTF_C_MRDI 3
`define CTF_C_AFED 4
`define CTF_C_MFE 5
`define CTF_C_AEN_LO 6
`define CTF_C_AEN_HI 9
`define CTF_C_IDLE 10
`define CTF_C_AIS 11
`define CTF_E_FRM_EN 0
`define CTF_E_P_EN 1
`define CTF_E_C_EN 2
`define CTF_E_FE_EN 3
`define CTF_E_MODE_LO 4
`define CTF_E_MODE_HI 5
`define CTF_E_P_CONT 6
`define CTF_E_C_CONT 7
`define CTF_E_FE_CONT 8
`define CTF_E_EXT_SRC 9
`define CTF_E_SWREQ 10
`define CTF_BIT_LAST 7'h54
`define CTF_BLK_LAST 3'h7
`define CTF_SF_LAST 3'h6
`define CTF_SF_P 3'h2
`define CTF_SF_C3 3'h2
`define CTF_SF_C4 3'h3
`define CTF_SF_C5 3'h4
`define CTF_SF_M1 3'h4
`define CTF_SF_M2 3'h5
`define CTF_SF_C1 3'h0
`define CTF_SF_C2 3'h1
`define CTF_BLK_F1 3'h1
`define CTF_BLK_F4 3'h7
`define CTF_CIDX_FIRST 2'h1
`define CTF_CIDX_LAST 2'h3
`define CTF_CNT_ONE 3'h1
`define CTF_CNT_TWO 3'h2
`define CTF_CNT_SEF 3'h4
`endif

/* File: rtl/ctf_pkg.sv */
// Types shared by the C-bit transmit formatter
package ctf_pkg;
  typedef enum logic [5:0] {
    SL_PAY = 6'h01,
    SL_X = 6'h02,
    SL_P = 6'h04,
    SL_M = 6'h08,
    SL_F = 6'h10,
    SL_C = 6'h20
  } ctf_slot_e;
  typedef enum logic [1:0] {
    FM_FBIT = 2'h0,
    FM_MBIT = 2'h1,
    FM_SEF = 2'h2,
    FM_OUT_OF_MULTIFRAME_ERROR_MODE = 2'h3
  } ctf_fmode_e;
  typedef struct packed {
    logic los;
    logic sef;
    logic lof;
    logic ais;
  } ctf_alarm_s;
  typedef struct packed {
    logic tx_overhead_data;
    logic tx_overhead_insert_enable;
  } ctf_oh_in_s;
endpackage

/* File: rtl/ctf_tx_formatter.sv */
// C-bit DS3 transmit formatter with APB control
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "ctf_defs.svh"

module ctf_err_arm (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic req_i,
  input wire logic en_i,
  input wire logic cont_i,
  input wire logic first_i,
  input wire logic in_grp_i,
  output logic hit_o,
  output logic pend_o
);
  logic pend_q;
  logic hold_q;
  logic take;
  assign take = en_i & (cont_i | pend_q);
  assign hit_o = in_grp_i & (first_i ? take : hold_q);
  assign pend_o = pend_q;
  // Request wins over the clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend_q <= 1'b0;
    end else if (req_i && en_i && !cont_i) begin
      pend_q <= 1'b1;
    end else if (first_i && take) begin
      pend_q <= 1'b0;
    end
  end
  // Decision held across the whole group of one frame
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_q <= 1'b0;
    end else if (first_i) begin
      hold_q <= take;
    end
  end
endmodule

// Summary of operation
// - With framing on, the three M bits are sent as 0, 1, 0.
// - With framing on, the four F bits of each subframe are 1, 0, 0, 1.
// - X bits carry RDI: manual value if auto disabled, else alarm state.
// - Each of LOS, SEF, LOF, AIS has its own RDI enable bit.
// - P bits carry XOR of all payload bits of the previous output frame.
// - P bits are made when parity generation or framing is enabled.
// - C-bits 1,2 of subframe 1 and all of subframes 2, 6, 7 are one.
// - Third C-bit of subframe 1 carries the alarm channel input bit.
// - Subframe 3 C-bits carry the same previous-frame parity as P bits.
// - Subframe 4 C-bits carry block error: register or auto from receiver.
// - Subframe 5 C-bits carry the data link bits from the HDLC side.
// - Order is generation, error insertion, overhead insertion; else pass.
// - Framing error mode: F bit, M bit, whole subframe F, or M twice.
// - P error inverts both P bits in one frame, single or continuous.
// - C parity error inverts all subframe 3 C-bits in one frame.
// - Block error insertion forces subframe 4 C-bits to zero one frame.
// - Separate enables; continuous hits every chance, single the next.
// - Requests come from a register bit or an input, chosen by config.
// - Overhead enable high in an overhead slot substitutes the input bit.
// - For P and subframe 3 C-bits the input bit is XORed as a mask.
// - Idle sends 1100 payload, normal M and F, X 11, parity bits.
// - AIS sends 1010 payload, X 11, parity, other C-bits 000; beats Idle.
module ctf_tx_formatter (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pay_bit_i,
  output logic line_bit_o,
  input wire ctf_pkg::ctf_alarm_s alarms_i,
  input wire ctf_pkg::ctf_oh_in_s oh_in_i,
  input wire logic far_end_alarm_channel_bit_i,
  input wire logic dl_bit_i,
  input wire logic rx_cp_err_prev_i,
  input wire logic manual_error_request_in_i,
  output logic tx_overhead_clock_o,
  output logic tx_overhead_frame_start_o,
  output logic dl_slot_o
);
  import ctf_pkg::*;

  logic [31:0] tx_framer_control_reg;
  logic [31:0] err_ctrl_q;
  logic [31:0] prdata_q;
  logic [6:0] bit_q;
  logic [2:0] blk_q;
  logic [2:0] sf_q;
  logic [2:0] frm_left_q;
  logic [2:0] frm_left_d;
  logic line_q;
  logic par_acc_q;
  logic par_prev_q;
  logic swreq_q;
  logic ext_q;
  logic req;
  logic frm_hit;
  logic p_hit;
  logic c_hit;
  logic fe_hit;
  logic p_pend;
  logic c_pend;
  logic fe_pend;
  logic v;
  logic fgen;
  logic pgen;
  logic ais;
  logic idle;
  logic rdi;
  logic far_end_block_error;
  logic m_val;
  logic f_val;
  logic c_val;
  logic last_pos;
  logic oh_en;
  logic [1:0] cidx;
  logic [6:0] bm1;
  logic [3:0] alarm_vec;
  logic wr;
  logic rd_setup;
  logic mapped;
  ctf_slot_e slot;
  ctf_fmode_e fmode;

  assign fgen = tx_framer_control_reg[`CTF_C_FGEN];
  assign pgen = tx_framer_control_reg[`CTF_C_PGEN];
  assign ais = tx_framer_control_reg[`CTF_C_AIS];
  assign idle = tx_framer_control_reg[`CTF_C_IDLE];
  assign fmode = ctf_fmode_e'(err_ctrl_q[`CTF_E_MODE_HI:`CTF_E_MODE_LO]);
  assign oh_en = oh_in_i.tx_overhead_insert_enable;
  assign cidx = blk_q[2:1];
  assign bm1 = bit_q - 7'h01;
  assign alarm_vec = {alarms_i.los, alarms_i.sef, alarms_i.lof, alarms_i.ais};

  // APB slave, zero wait states, error on unmapped address
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd_setup = psel_i & ~penable_i;
  assign mapped = (paddr_i == `CTF_CTRL_OFS) || (paddr_i == `CTF_ERR_OFS) ||
                  (paddr_i == `CTF_STAT_OFS);
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~mapped;
  assign prdata_o = prdata_q;

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_framer_control_reg <= `CTF_CTRL_RST;
      err_ctrl_q <= `CTF_ERR_RST;
    end else if (wr) begin
      if (paddr_i == `CTF_CTRL_OFS) begin
        tx_framer_control_reg <= {20'h0_0000, pwdata_i[11:0]};
      end else if (paddr_i == `CTF_ERR_OFS) begin
        err_ctrl_q <= {22'h00_0000, pwdata_i[9:0]};
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prdata_q <= 32'h0000_0000;
    end else if (rd_setup) begin
      if (paddr_i == `CTF_CTRL_OFS) begin
        prdata_q <= tx_framer_control_reg;
      end else if (paddr_i == `CTF_ERR_OFS) begin
        prdata_q <= err_ctrl_q;
      end else if (paddr_i == `CTF_STAT_OFS) begin
        prdata_q <= {12'h000, par_prev_q, fe_pend, c_pend, p_pend,
                     frm_left_q, sf_q, blk_q, bit_q};
      end else begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  // Error request from register bit or rising edge of input
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      swreq_q <= 1'b0;
      ext_q <= 1'b0;
    end else begin
      swreq_q <= wr && (paddr_i == `CTF_ERR_OFS) && pwdata_i[`CTF_E_SWREQ];
      ext_q <= manual_error_request_in_i;
    end
  end
  assign req = err_ctrl_q[`CTF_E_EXT_SRC] ?
               (manual_error_request_in_i & ~ext_q) : swreq_q;

  // Frame position: 7 subframes x 8 blocks x 85 bits
  assign last_pos = (bit_q == `CTF_BIT_LAST) && (blk_q == `CTF_BLK_LAST) &&
                    (sf_q == `CTF_SF_LAST);
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_q <= 7'h00;
      blk_q <= 3'h0;
      sf_q <= 3'h0;
    end else if (bit_q != `CTF_BIT_LAST) begin
      bit_q <= bit_q + 7'h01;
    end else begin
      bit_q <= 7'h00;
      blk_q <= blk_q + 3'h1;
      if (blk_q == `CTF_BLK_LAST) begin
        sf_q <= (sf_q == `CTF_SF_LAST) ? 3'h0 : sf_q + 3'h1;
      end
    end
  end

  always_comb begin
    slot = SL_PAY;
    if (bit_q == 7'h00) begin
      if (blk_q[0]) begin
        slot = SL_F;
      end else if (blk_q != 3'h0) begin
        slot = SL_C;
      end else if (sf_q < `CTF_SF_P) begin
        slot = SL_X;
      end else if (sf_q < `CTF_SF_M1) begin
        slot = SL_P;
      end else begin
        slot = SL_M;
      end
    end
  end
  assign tx_overhead_clock_o = (slot != SL_PAY);
  assign tx_overhead_frame_start_o = (bit_q == 7'h00) && (blk_q == 3'h0) &&
                                     (sf_q == 3'h0);
  assign dl_slot_o = (slot == SL_C) && (sf_q == `CTF_SF_C5);

  // Overhead values
  assign m_val = (sf_q == `CTF_SF_M2);
  assign f_val = (blk_q == `CTF_BLK_F1) || (blk_q == `CTF_BLK_F4);
  assign rdi = tx_framer_control_reg[`CTF_C_ARDD] ?
               tx_framer_control_reg[`CTF_C_MRDI] :
               ~|(alarm_vec &
               tx_framer_control_reg[`CTF_C_AEN_HI:`CTF_C_AEN_LO]);
  assign far_end_block_error = tx_framer_control_reg[`CTF_C_AFED] ?
                tx_framer_control_reg[`CTF_C_MFE] : ~rx_cp_err_prev_i;

  always_comb begin
    c_val = 1'b1;
    if (sf_q == `CTF_SF_C1) begin
      c_val = (cidx == `CTF_CIDX_LAST) ? far_end_alarm_channel_bit_i : 1'b1;
    end else if (sf_q == `CTF_SF_C3) begin
      c_val = par_prev_q;
    end else if (sf_q == `CTF_SF_C4) begin
      c_val = far_end_block_error;
    end else if (sf_q == `CTF_SF_C5) begin
      c_val = dl_bit_i;
    end
  end

  // Error opportunity units for P, C-parity and block error
  ctf_err_arm u_p_err (
    .clk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req),
    .en_i(err_ctrl_q[`CTF_E_P_EN]), .cont_i(err_ctrl_q[`CTF_E_P_CONT]),
    .first_i((slot == SL_P) && (sf_q == `CTF_SF_P)),
    .in_grp_i(slot == SL_P), .hit_o(p_hit), .pend_o(p_pend)
  );
  ctf_err_arm u_c_err (
    .clk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req),
    .en_i(err_ctrl_q[`CTF_E_C_EN]), .cont_i(err_ctrl_q[`CTF_E_C_CONT]),
    .first_i((slot == SL_C) && (sf_q == `CTF_SF_C3) &&
             (cidx == `CTF_CIDX_FIRST)),
    .in_grp_i((slot == SL_C) && (sf_q == `CTF_SF_C3)),
    .hit_o(c_hit), .pend_o(c_pend)
  );
  ctf_err_arm u_fe_err (
    .clk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(req),
    .en_i(err_ctrl_q[`CTF_E_FE_EN]), .cont_i(err_ctrl_q[`CTF_E_FE_CONT]),
    .first_i((slot == SL_C) && (sf_q == `CTF_SF_C4) &&
             (cidx == `CTF_CIDX_FIRST)),
    .in_grp_i((slot == SL_C) && (sf_q == `CTF_SF_C4)),
    .hit_o(fe_hit), .pend_o(fe_pend)
  );

  // Framing errors: a request loads the count of bits to corrupt
  always_comb begin
    frm_hit = 1'b0;
    if (frm_left_q != 3'h0) begin
      case (fmode)
        FM_FBIT: frm_hit = (slot == SL_F);
        FM_MBIT: frm_hit = (slot == SL_M);
        FM_SEF: frm_hit = (slot == SL_F) && ((frm_left_q != `CTF_CNT_SEF) ||
                          (blk_q == `CTF_BLK_F1));
        default: frm_hit = (slot == SL_M) && (sf_q == `CTF_SF_M1);
      endcase
    end
  end
  always_comb begin
    frm_left_d = frm_left_q;
    if (req && err_ctrl_q[`CTF_E_FRM_EN]) begin
      case (fmode)
        FM_SEF: frm_left_d = `CTF_CNT_SEF;
        FM_OUT_OF_MULTIFRAME_ERROR_MODE: frm_left_d = `CTF_CNT_TWO;
        default: frm_left_d = `CTF_CNT_ONE;
      endcase
    end else if (frm_hit) begin
      frm_left_d = frm_left_q - 3'h1;
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      frm_left_q <= 3'h0;
    end else begin
      frm_left_q <= frm_left_d;
    end
  end

  // Bit path: generation, errors, overhead insertion, AIS and Idle
  always_comb begin
    v = pay_bit_i;
    if (fgen) begin
      case (slot)
        SL_X: v = rdi;
        SL_P: v = par_prev_q;
        SL_M: v = m_val;
        SL_F: v = f_val;
        SL_C: v = c_val;
        default: v = pay_bit_i;
      endcase
    end else if (pgen && (slot == SL_P)) begin
      v = par_prev_q;
    end
    if (frm_hit || p_hit || c_hit) begin
      v = ~v;
    end
    if (fe_hit) begin
      v = 1'b0;
    end
    if ((slot != SL_PAY) && oh_en) begin
      if ((slot == SL_P) || ((slot == SL_C) && (sf_q == `CTF_SF_C3))) begin
        v = v ^ oh_in_i.tx_overhead_data;
      end else begin
        v = oh_in_i.tx_overhead_data;
      end
    end
    if (ais || idle) begin
      case (slot)
        SL_PAY: v = ais ? bit_q[0] : ~bm1[1];
        SL_X: v = 1'b1;
        SL_P: v = par_prev_q;
        SL_M: v = m_val;
        SL_F: v = f_val;
        default: begin
          if (sf_q == `CTF_SF_C3) begin
            v = par_prev_q;
          end else if (ais) begin
            v = 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_q <= 1'b0;
    end else begin
      line_q <= v;
    end
  end
  assign line_bit_o = line_q;

  // Parity of the output payload, frozen at each frame end
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      par_acc_q <= 1'b0;
      par_prev_q <= 1'b0;
    end else if (last_pos) begin
      par_acc_q <= 1'b0;
      par_prev_q <= par_acc_q ^ v;
    end else if (slot == SL_PAY) begin
      par_acc_q <= par_acc_q ^ v;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_mbit_value: assert property (fgen && !ais && !idle && !oh_en &&
    slot == SL_M && !frm_hit |=> line_q == $past(sf_q == `CTF_SF_M2))
    else $error("M bit value wrong");
  a_fbit_value: assert property (fgen && !ais && !idle && !oh_en &&
    slot == SL_F && !frm_hit |=> line_q == $past(f_val))
    else $error("F bit value wrong");
  a_xbit_manual: assert property (fgen && !ais && !idle && !oh_en &&
    slot == SL_X && tx_framer_control_reg[`CTF_C_ARDD] |=>
    line_q == $past(tx_framer_control_reg[`CTF_C_MRDI]))
    else $error("Manual RDI not sent");
  a_pbit_parity: assert property ((fgen || pgen) && !ais && !idle &&
    !oh_en && slot == SL_P && !p_hit |=> line_q == $past(par_prev_q))
    else $error("P bit not parity");
  a_c2_ones: assert property (fgen && !ais && !idle && !oh_en &&
    slot == SL_C && sf_q == `CTF_SF_C2 |=> line_q)
    else $error("Unused C bit not one");
  a_far_end_block_error_force: assert property (fe_hit && !oh_en && !ais &&
    !idle |=> !line_q)
    else $error("Block error not forced");
  a_oh_override: assert property (oh_en && slot == SL_F && !ais &&
    !idle |=> line_q == $past(oh_in_i.tx_overhead_data))
    else $error("Overhead input not inserted");
  a_oh_xor_mask: assert property (fgen && oh_en && slot == SL_P &&
    !ais && !idle |=> line_q ==
    $past(par_prev_q ^ oh_in_i.tx_overhead_data ^ p_hit))
    else $error("P mask not applied");
  a_ais_payload: assert property (ais && slot == SL_PAY |=>
    line_q == $past(bit_q[0]))
    else $error("AIS payload wrong");
  a_idle_xbits: assert property (idle && slot == SL_X |=> line_q)
    else $error("Idle X bit not one");
  a_frame_wrap: assert property (last_pos |=>
    tx_overhead_frame_start_o && tx_overhead_clock_o)
    else $error("Frame counter wrap wrong");
  a_sef_run: assert property (frm_hit && fmode == FM_SEF &&
    blk_q == `CTF_BLK_F1 && !req |-> ##170 frm_hit)
    else $error("SEF run broken");

  c_ais_frame: cover property (ais && last_pos);
  c_sef_insert: cover property (frm_hit && fmode == FM_SEF);
  c_out_of_multiframe_error_mode_insert: cover property (frm_hit && fmode == FM_OUT_OF_MULTIFRAME_ERROR_MODE);
  c_oh_insert: cover property (oh_en && slot == SL_C);
endmodule

/* File: bench/ctf_line_partner.sv */
// Downstream line monitor and external overhead source model
`timescale 1ns/1ps
module ctf_line_partner (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic ohclk_i,
  input wire logic sof_i,
  input wire logic line_i,
  input wire logic [55:0] mask_i,
  input wire logic [55:0] data_i,
  input wire logic [1:0] pat_i,
  output ctf_pkg::ctf_oh_in_s oh_o,
  output logic [55:0] bits_o,
  output logic par_o,
  output logic done_o,
  output logic [15:0] bad_o
);
  import ctf_pkg::*;
  logic [5:0] idx_q;
  logic [5:0] idx_d;
  logic [5:0] cap_q;
  logic clk_q;
  logic tog_q;
  logic par_q;
  logic [6:0] run_q;
  logic exp_w;
  logic ins_w;
  // Slot count restarts at the frame start marker
  assign idx_d = sof_i ? 6'h00 : idx_q + 6'h01;
  assign ins_w = ohclk_i & mask_i[idx_d];
  // Data line toggles while not inserting
  assign oh_o = {(ins_w ? data_i[idx_d] : tog_q), ins_w};
  assign exp_w = (pat_i == 2'h2) ? ~run_q[0] : ~run_q[1];
  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      idx_q <= 6'h00;
      cap_q <= 6'h00;
      clk_q <= 1'b0;
      tog_q <= 1'b0;
      par_q <= 1'b0;
      run_q <= 7'h00;
      bits_o <= 56'h00_0000_0000_0000;
      par_o <= 1'b0;
      done_o <= 1'b0;
      bad_o <= 16'h0000;
    end else begin
      tog_q <= ~tog_q;
      clk_q <= ohclk_i;
      cap_q <= idx_d;
      done_o <= clk_q && (cap_q == 6'h37);
      if (ohclk_i) begin
        idx_q <= idx_d;
      end
      if (clk_q) begin
        bits_o[cap_q] <= line_i;
        run_q <= 7'h00;
        if (cap_q == 6'h00) begin
          par_o <= par_q;
          par_q <= 1'b0;
        end
      end else begin
        par_q <= par_q ^ line_i;
        run_q <= run_q + 7'h01;
        if (pat_i != 2'h0 && line_i !== exp_w) begin
          bad_o <= bad_o + 16'h0001;
        end
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the C-bit transmit formatter
`timescale 1ns/1ps
`include "ctf_defs.svh"
module tb_top;
  import ctf_pkg::*;
  localparam logic [55:0] Z = 56'h00_0000_0000_0000;
  localparam logic [55:0] PM = 56'h00_0000_0101_0000;
  localparam logic [55:0] CM = 56'h00_0000_0054_0000;
  localparam logic [55:0] M1 = 56'h00_0001_0000_0000;
  localparam logic [55:0] OHM = 56'h00_0000_0005_0006;
  logic mclk_i, rst_b_i, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic pay, line, far_end_alarm_channel, dl, rxcp, mreq, ohclk, sof, ppar, done, cst;
  logic dls;
  logic [7:0] dln;
  logic [2:0] pc;
  logic [1:0] pat;
  logic [3:0] aen;
  logic [15:0] patb;
  logic [55:0] ohb, mask, idata;
  ctf_alarm_s alarms;
  ctf_oh_in_s ohin;
  int errors, tests_run;
  ctf_tx_formatter u_dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .pay_bit_i(pay),
    .line_bit_o(line), .alarms_i(alarms), .oh_in_i(ohin),
    .far_end_alarm_channel_bit_i(far_end_alarm_channel), .dl_bit_i(dl), .rx_cp_err_prev_i(rxcp),
    .manual_error_request_in_i(mreq), .tx_overhead_clock_o(ohclk),
    .tx_overhead_frame_start_o(sof), .dl_slot_o(dls));
  ctf_line_partner u_far (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
    .ohclk_i(ohclk), .sof_i(sof), .line_i(line), .mask_i(mask),
    .data_i(idata), .pat_i(pat), .oh_o(ohin), .bits_o(ohb),
    .par_o(ppar), .done_o(done), .bad_o(patb));
  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end
  always @(posedge mclk_i) begin
    pc <= pc + 3'h1;
    pay <= cst | (pc[2] ^ pc[0]);
    dln <= sof ? 8'h00 : dln + {7'h00, dls};
  end
  task automatic final_report();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_frame(input logic [55:0] e);
    tests_run++;
    if (ohb !== e) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, ohb, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      errors++;
      final_report();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      @(negedge mclk_i);
      n++;
    end while (done !== 1'b1 && n < 6000);
    if (done !== 1'b1) begin
      errors++;
      final_report();
    end
  endtask
  function automatic logic [55:0] ex(input logic x, input logic p,
    input logic fb, input int md);
    logic [55:0] v;
    int sf;
    int b;
    for (int k = 0; k < 56; k++) begin
      sf = k / 8;
      b = k % 8;
      if (md >= 3) begin
        v[k] = (md == 3 && b == 0 && (sf == 2 || sf == 3)) ? p : 1'b1;
      end else if (b == 0) begin
        v[k] = (sf < 2) ? x : (sf < 4) ? p : (sf == 5);
      end else if (b % 2 == 1) begin
        v[k] = (b == 1 || b == 7);
      end else if (md == 2 && sf != 2) begin
        v[k] = 1'b0;
      end else begin
        v[k] = (sf == 0) ? (b != 6 || far_end_alarm_channel) : (sf == 2) ? p :
          (sf == 3) ? fb : (sf == 4) ? dl : 1'b1;
      end
    end
    return v;
  endfunction
  task automatic step(input logic [31:0] c, input logic [31:0] e,
    input logic x, input logic fb, input int md, input logic [55:0] fl);
    logic [15:0] pb;
    logic p;
    apb(1'b1, `CTF_CTRL_OFS, c);
    apb(1'b1, `CTF_ERR_OFS, e);
    if (e[`CTF_E_EXT_SRC]) begin
      @(posedge mclk_i);
      mreq <= 1'b1;
    end
    if (md == 1 || md == 2) begin
      wait_done();
      @(posedge mclk_i);
      pat <= md[1:0];
    end
    @(negedge mclk_i);
    pb = patb;
    wait_done();
    p = (pat != 2'h0) ? 1'b0 : ppar;
    chk_frame(ex(x, p, fb, md) ^ fl);
    chk_val({24'h00_0000, dln}, 32'h0000_0003);
    if (pat != 2'h0) chk_val({16'h0000, patb}, {16'h0000, pb});
    @(posedge mclk_i);
    pat <= 2'h0;
    mreq <= 1'b0;
  endtask
  initial begin
    errors = 0;
    tests_run = 0;
    rst_b_i = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pay = 1'b0;
    pc = 3'h0;
    cst = 1'b0;
    alarms = 4'h0;
    far_end_alarm_channel = 1'b1;
    dl = 1'b1;
    rxcp = 1'b1;
    mreq = 1'b0;
    pat = 2'h0;
    mask = Z;
    idata = Z;
    repeat (3) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    apb(1'b0, `CTF_CTRL_OFS, 32'h0000_0000);
    chk_val(rdat, `CTF_CTRL_RST);
    apb(1'b0, `CTF_ERR_OFS, 32'h0000_0000);
    chk_val(rdat, `CTF_ERR_RST);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk_val({rerr, rdat[30:0]}, 32'h8000_0000);
    apb(1'b1, `CTF_ERR_OFS, 32'h0000_0600);
    apb(1'b0, `CTF_ERR_OFS, 32'h0000_0000);
    chk_val(rdat, 32'h0000_0200);
    wait_done();
    step(32'h0000_03c1, 32'h0, 1'b1, 1'b0, 0, Z);
    for (int i = 0; i < 4; i++) begin
      alarms <= 4'h1 << i;
      far_end_alarm_channel <= i[0];
      dl <= i[1];
      rxcp <= ~i[0];
      aen = (i < 2) ? (4'h1 << i) : ~(4'h1 << i);
      step({22'h0, aen, 6'h01}, 32'h0, i >= 2, i[0], 0, Z);
    end
    alarms <= 4'hf;
    rxcp <= 1'b1;
    step(32'h0000_03fd, 32'h0, 1'b1, 1'b1, 0, Z);
    rxcp <= 1'b0;
    step(32'h0000_03d5, 32'h0, 1'b0, 1'b0, 0, Z);
    alarms <= 4'h0;
    cst <= 1'b1;
    step(32'h0000_0002, 32'h0, 1'b1, 1'b1, 3, Z);
    step(32'h0000_0000, 32'h0, 1'b1, 1'b1, 4, Z);
    cst <= 1'b0;
    step(32'h0000_03f1, 32'h0000_01ce, 1'b1, 1'b0, 0, PM | CM);
    step(32'h0000_03f1, 32'h0000_040f, 1'b1, 1'b0, 0, PM | CM | 56'h2);
    step(32'h0000_03f1, 32'h0000_000f, 1'b1, 1'b1, 0, Z);
    step(32'h0000_03f1, 32'h0000_0211, 1'b1, 1'b1, 0, M1);
    step(32'h0000_03f1, 32'h0000_0421, 1'b1, 1'b1, 0, 56'haa);
    step(32'h0000_03f1, 32'h0000_0431, 1'b1, 1'b1, 0, M1);
    step(32'h0000_03f1, 32'h0000_0031, 1'b1, 1'b1, 0, M1);
    mask <= OHM;
    idata <= 56'h00_0000_0005_0000;
    step(32'h0000_03f1, 32'h0, 1'b1, 1'b1, 0, OHM);
    mask <= Z;
    step(32'h0000_07f1, 32'h0, 1'b1, 1'b1, 1, Z);
    step(32'h0000_0ff1, 32'h0, 1'b1, 1'b1, 2, Z);
    final_report();
  end
endmodule
